// [verilog/hcf_map.vh]
// Purpose : Register offsets, fields, reset values and timing of the configuration block
// Assumes : Included by the design files of the hcf block
// Notes   : Definitions only
`ifndef HCF_MAP_VH
`define HCF_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define HCF_OFF_BYTE_TEST   12'h064
`define HCF_OFF_HARDWARE_CONFIGURATION      12'h074
`define HCF_OFF_POWER_MGMT_CONTROL    12'h084
`define HCF_OFF_RESET_CONTROL_REG   12'h0F8
`define HCF_OFF_SCRATCH     12'h0A0
`define HCF_OFF_ERR_STS     12'h0A4
`define HCF_OFF_PART_TX     12'h0A8
`define HCF_OFF_PART_RX     12'h0AC
`define HCF_SOFT_LIMIT      12'h100

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define HCF_BIT_SOFT_RST    0
`define HCF_BIT_READY       27
`define HCF_BIT_PMT_READY   0
`define HCF_BIT_MBO         20
`define HCF_BIT_RSV21       21
`define HCF_TXSZ_LSB        16
`define HCF_TXSZ_MSB        19
`define HCF_RSV_LSB         12
`define HCF_RSV_MSB         13
`define HCF_TXSZ_RESET      4'h5
`define HCF_TXSZ_MAX        4'hE
`define HCF_BIT_DIG_RST     0
`define HCF_BIT_PME_TYPE    6
`define HCF_BIT_TXE         0
`define HCF_BIT_RXE         1
`define HCF_BYTE_TEST_VAL   32'h8765_4321
`define HCF_ZERO            32'h0000_0000

// ----------------------------------------------------------------------------
// FIFO partition (bytes)
// ----------------------------------------------------------------------------
`define HCF_TOTAL_BYTES     15'h4000
`define HCF_TX_STS_BYTES    15'h0200
`define HCF_KB_SHIFT        10

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define HCF_CLK_MHZ         100
`define HCF_SOFT_RESET_REQUEST_NS         200
`define HCF_READY_NS        1000

`endif

// [verilog/hcf_partition.v]
// Purpose : Derive TX status, TX data and RX region sizes from the TX allocation
// Assumes : Same clock and reset as the register block
// Notes   : Sizes are registered so they change one cycle after a write
`include "hcf_map.vh"
`default_nettype none

module hcf_partition (
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // Allocation in kilobytes
  input  wire [3:0]  alloc_kb_in,
  // Region sizes in bytes
  output reg  [14:0] tx_sts_bytes_out,
  output reg  [14:0] tx_data_bytes_out,
  output reg  [14:0] rx_bytes_out
);

  wire [14:0] tx_total;

  assign tx_total = {1'b0, alloc_kb_in, 10'h000};

  // ----------------------------------------------------------------------------
  // Split: status fixed, data takes the rest, RX takes what TX leaves
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      tx_sts_bytes_out  <= `HCF_TX_STS_BYTES;
      tx_data_bytes_out <= 15'h0000;
      rx_bytes_out      <= 15'h0000;
    end else begin
      tx_sts_bytes_out  <= `HCF_TX_STS_BYTES;
      tx_data_bytes_out <= tx_total - `HCF_TX_STS_BYTES;
      rx_bytes_out      <= `HCF_TOTAL_BYTES - tx_total;
    end
  end

endmodule // hcf_partition
`default_nettype wire

// [verilog/hcf_reset_seq.v]
// Purpose : Hold soft reset for a fixed time and time the ready flag
// Assumes : Requests are single-cycle pulses on the system clock
// Notes   : Ready rises a fixed time after every reset ends
`include "hcf_map.vh"
`default_nettype none

module hcf_reset_seq #(
  parameter SOFT_RESET_REQUEST_CYCLES  = 20,
  parameter READY_CYCLES = 100
) (
  // Clock and reset
  input  wire clk_sys_in,
  input  wire rst_in,
  // Requests
  input  wire soft_req_in,
  input  wire dig_req_in,
  // Status
  output reg  soft_active_out,
  output reg  dig_active_out,
  output reg  done_out,
  output reg  ready_out
);

  reg [7:0]  hold_cnt;
  reg [11:0] rdy_cnt;

  always @(posedge clk_sys_in) begin
    done_out <= 1'b0;
    if (rst_in) begin
      soft_active_out <= 1'b0;
      dig_active_out  <= 1'b0;
      hold_cnt        <= 8'h00;
      rdy_cnt         <= 12'h000;
      ready_out       <= 1'b0;
    end else if (dig_req_in || soft_req_in) begin
      dig_active_out  <= dig_req_in | dig_active_out;
      soft_active_out <= 1'b1;
      hold_cnt        <= SOFT_RESET_REQUEST_CYCLES[7:0] - 8'h01;
      ready_out       <= 1'b0;
      rdy_cnt         <= 12'h000;
    end else if (soft_active_out) begin
      if (hold_cnt == 8'h00) begin
        soft_active_out <= 1'b0;
        dig_active_out  <= 1'b0;
        done_out        <= 1'b1;
      end else begin
        hold_cnt <= hold_cnt - 8'h01;
      end
    end else if (!ready_out) begin
      if (rdy_cnt == READY_CYCLES[11:0] - 12'h001)
        ready_out <= 1'b1;
      else
        rdy_cnt <= rdy_cnt + 12'h001;
    end
  end

endmodule // hcf_reset_seq
`default_nettype wire

// [verilog/hcf_config_regs.v]
// Purpose : Hardware configuration and power management registers over APB
// Assumes : APB slave, zero wait states, 12-bit byte address
// Notes   : Soft reset clears registers below 100h except kept bits
`include "hcf_map.vh"
`default_nettype none

module hcf_config_regs #(
  parameter SOFT_RESET_REQUEST_CYCLES  = (`HCF_SOFT_RESET_REQUEST_NS * `HCF_CLK_MHZ + 999) / 1000,
  parameter READY_CYCLES = (`HCF_READY_NS * `HCF_CLK_MHZ + 999) / 1000
) (
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // MAC error events
  input  wire        tx_err_event_in,
  input  wire        rx_err_event_in,
  // Reset and partition outputs
  output reg         host_soft_reset_out,
  output reg         device_ready_out,
  output reg  [14:0] tx_sts_bytes_out,
  output reg  [14:0] tx_data_bytes_out,
  output reg  [14:0] rx_bytes_out
);

  // ----------------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------------
  reg [3:0]  tx_fifo_alloc_kb;
  reg [1:0]  cfg_rsv;
  reg        cfg_mbo;
  reg        cfg_rsv21;
  reg        kept_through_soft_reset;
  reg [31:0] scratch;
  reg        tx_error_flag;
  reg        rx_error_flag;
  reg        tx_err_s1;
  reg        tx_err_s2;
  reg        rx_err_s1;
  reg        rx_err_s2;

  wire        soft_active;
  wire        dig_active;
  wire        seq_done;
  wire        ready;
  wire [14:0] part_sts;
  wire [14:0] part_data;
  wire [14:0] part_rx;

  // ----------------------------------------------------------------------------
  // Bus phase decode
  // ----------------------------------------------------------------------------
  wire setup   = psel_in & ~penable_in;
  wire access  = psel_in & penable_in;
  wire wr      = access & pwrite_in;
  wire rd      = access & ~pwrite_in;

  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // Registers that stay reachable while the device is not ready
  function early_ok;
    input [11:0] addr;
    begin
      early_ok = hit(addr, `HCF_OFF_HARDWARE_CONFIGURATION) | hit(addr, `HCF_OFF_POWER_MGMT_CONTROL) |
                 hit(addr, `HCF_OFF_BYTE_TEST) | hit(addr, `HCF_OFF_RESET_CONTROL_REG);
    end
  endfunction

  wire soft_req = wr & hit(paddr_in, `HCF_OFF_HARDWARE_CONFIGURATION) &
                  pwdata_in[`HCF_BIT_SOFT_RST] & ~soft_active;
  wire dig_req  = wr & hit(paddr_in, `HCF_OFF_RESET_CONTROL_REG) &
                  pwdata_in[`HCF_BIT_DIG_RST] & ~soft_active;
  // Writes while not ready are dropped, except reset requests outside the soft reset hold
  wire wr_ok    = wr & ready & ~soft_active;

  // ----------------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------------
  wire       wr_cfg     = wr_ok & hit(paddr_in, `HCF_OFF_HARDWARE_CONFIGURATION);
  wire       wr_pmt     = wr_ok & hit(paddr_in, `HCF_OFF_POWER_MGMT_CONTROL);
  wire       wr_scratch = wr_ok & hit(paddr_in, `HCF_OFF_SCRATCH);
  wire       wr_err     = wr_ok & hit(paddr_in, `HCF_OFF_ERR_STS);
  wire [3:0] alloc_req  = pwdata_in[`HCF_TXSZ_MSB:`HCF_TXSZ_LSB];
  wire       alloc_big  = (alloc_req > `HCF_TXSZ_MAX);
  // Write-one-to-clear strobes for the latched error flags
  wire       clr_txe    = wr_err & pwdata_in[`HCF_BIT_TXE];
  wire       clr_rxe    = wr_err & pwdata_in[`HCF_BIT_RXE];
  // Soft reset bit reads one for the whole hold and during digital reset
  wire       soft_reset_request_busy  = soft_active | dig_active;

  // ----------------------------------------------------------------------------
  // Reset sequencing and partition
  // ----------------------------------------------------------------------------
  hcf_reset_seq #(
    .SOFT_RESET_REQUEST_CYCLES  (SOFT_RESET_REQUEST_CYCLES),
    .READY_CYCLES (READY_CYCLES)
  ) u_seq (
    .clk_sys_in      (clk_sys_in),
    .rst_in          (rst_in),
    .soft_req_in     (soft_req | dig_req),
    .dig_req_in      (dig_req),
    .soft_active_out (soft_active),
    .dig_active_out  (dig_active),
    .done_out        (seq_done),
    .ready_out       (ready)
  );

  hcf_partition u_part (
    .clk_sys_in        (clk_sys_in),
    .rst_in            (rst_in),
    .alloc_kb_in       (tx_fifo_alloc_kb),
    .tx_sts_bytes_out  (part_sts),
    .tx_data_bytes_out (part_data),
    .rx_bytes_out      (part_rx)
  );

  // ----------------------------------------------------------------------------
  // Error event synchronisers
  // ----------------------------------------------------------------------------
  // Events come from the MAC side; only the second stage is read
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      tx_err_s1 <= 1'b0;
      tx_err_s2 <= 1'b0;
      rx_err_s1 <= 1'b0;
      rx_err_s2 <= 1'b0;
    end else begin
      tx_err_s1 <= tx_err_event_in;
      tx_err_s2 <= tx_err_s1;
      rx_err_s1 <= rx_err_event_in;
      rx_err_s2 <= rx_err_s1;
    end
  end

  // ----------------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (rst_in || dig_active) begin
      tx_fifo_alloc_kb        <= `HCF_TXSZ_RESET;
      cfg_rsv                 <= 2'b00;
      cfg_mbo                 <= 1'b0;
      cfg_rsv21               <= 1'b0;
      kept_through_soft_reset <= 1'b0;
      scratch                 <= `HCF_ZERO;
      tx_error_flag           <= 1'b0;
      rx_error_flag           <= 1'b0;
    end else if (soft_active) begin
      // Kept bits hold; everything else below 100h returns to default
      tx_fifo_alloc_kb <= `HCF_TXSZ_RESET;
      cfg_rsv          <= 2'b00;
      cfg_mbo          <= 1'b0;
      cfg_rsv21        <= 1'b0;
      scratch          <= `HCF_ZERO;
      tx_error_flag    <= 1'b0;
      rx_error_flag    <= 1'b0;
    end else begin
      if (wr_cfg) begin
        // Values above the maximum clamp so RX never underflows
        if (alloc_big)
          tx_fifo_alloc_kb <= `HCF_TXSZ_MAX;
        else
          tx_fifo_alloc_kb <= alloc_req;
        cfg_rsv   <= pwdata_in[`HCF_RSV_MSB:`HCF_RSV_LSB];
        cfg_mbo   <= pwdata_in[`HCF_BIT_MBO];
        cfg_rsv21 <= pwdata_in[`HCF_BIT_RSV21];
      end
      // Kept bit survives soft reset; only rst_in, digital reset or a power management write of zero clears it
      if (wr_pmt)
        kept_through_soft_reset <= pwdata_in[`HCF_BIT_PME_TYPE];
      if (wr_scratch)
        scratch <= pwdata_in;
      // Set wins over a same-cycle write-one clear
      if (tx_err_s2)
        tx_error_flag <= 1'b1;
      else if (clr_txe)
        tx_error_flag <= 1'b0;
      if (rx_err_s2)
        rx_error_flag <= 1'b1;
      else if (clr_rxe)
        rx_error_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------------
  reg [31:0] rd_val;
  reg        rd_err;

  always @* begin
    rd_val = `HCF_ZERO;
    rd_err = 1'b0;
    if (!ready && !early_ok(paddr_in)) begin
      rd_err = 1'b1;
    end else if (hit(paddr_in, `HCF_OFF_HARDWARE_CONFIGURATION)) begin
      rd_val[`HCF_BIT_READY]               = ready;
      rd_val[`HCF_BIT_RSV21]               = cfg_rsv21;
      rd_val[`HCF_BIT_MBO]                 = cfg_mbo;
      rd_val[`HCF_TXSZ_MSB:`HCF_TXSZ_LSB]  = tx_fifo_alloc_kb;
      rd_val[`HCF_RSV_MSB:`HCF_RSV_LSB]    = cfg_rsv;
      rd_val[`HCF_BIT_SOFT_RST]            = soft_reset_request_busy;
    end else if (hit(paddr_in, `HCF_OFF_POWER_MGMT_CONTROL)) begin
      rd_val[`HCF_BIT_PMT_READY] = ready;
      rd_val[`HCF_BIT_PME_TYPE]  = kept_through_soft_reset;
    end else if (hit(paddr_in, `HCF_OFF_BYTE_TEST)) begin
      rd_val = `HCF_BYTE_TEST_VAL;
    end else if (hit(paddr_in, `HCF_OFF_RESET_CONTROL_REG)) begin
      rd_val[`HCF_BIT_DIG_RST] = dig_active;
    end else if (hit(paddr_in, `HCF_OFF_SCRATCH)) begin
      rd_val = scratch;
    end else if (hit(paddr_in, `HCF_OFF_ERR_STS)) begin
      rd_val[`HCF_BIT_TXE] = tx_error_flag;
      rd_val[`HCF_BIT_RXE] = rx_error_flag;
    end else if (hit(paddr_in, `HCF_OFF_PART_TX)) begin
      rd_val = {2'b00, part_data, part_sts};
    end else if (hit(paddr_in, `HCF_OFF_PART_RX)) begin
      rd_val = {17'h0_0000, part_rx};
    end else begin
      rd_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // APB answer: no wait state, answer registered in the setup cycle
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      prdata_out  <= `HCF_ZERO;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= setup;
      if (setup) begin
        prdata_out  <= pwrite_in ? `HCF_ZERO : rd_val;
        pslverr_out <= pwrite_in ? 1'b0 : rd_err;
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  // Registered again so every port comes straight from a flip-flop
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      host_soft_reset_out <= 1'b1;
      device_ready_out    <= 1'b0;
      tx_sts_bytes_out    <= 15'h0000;
      tx_data_bytes_out   <= 15'h0000;
      rx_bytes_out        <= 15'h0000;
    end else begin
      host_soft_reset_out <= soft_active | seq_done;
      device_ready_out    <= ready;
      tx_sts_bytes_out    <= part_sts;
      tx_data_bytes_out   <= part_data;
      rx_bytes_out        <= part_rx;
    end
  end

  // Rd and unused wires are kept for clarity of decode
  wire unused_rd = rd;

endmodule // hcf_config_regs
`default_nettype wire

// [verif/hcf_config_regs_properties.sv]
// Purpose : Port-level properties of the configuration register block
// Assumes : One clock domain, synchronous active-high reset, soft reset held >= 4 cycles
// Notes   : Bound to every instance of the block
`default_nettype none

module hcf_config_regs_properties #(
  parameter SOFT_RESET_REQUEST_CYCLES  = 6,
  parameter READY_CYCLES = 16
) (
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  // APB
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Status
  input wire logic        host_soft_reset_out,
  input wire logic        device_ready_out,
  input wire logic [14:0] tx_sts_bytes_out,
  input wire logic [14:0] tx_data_bytes_out,
  input wire logic [14:0] rx_bytes_out
);
  localparam int SOFT_RESET_REQUEST_LIM = SOFT_RESET_REQUEST_CYCLES + 4;
  localparam int RDY_LIM  = READY_CYCLES + 8;
  wire rd_done = psel_in && penable_in && pready_out && !pwrite_in;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  sequence s_soft_reset_request_wr;
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h074 && pwdata_in[0]
      && device_ready_out && !host_soft_reset_out;
  endsequence
  sequence s_soft_reset_request_hold;
    ##[1:4] host_soft_reset_out [*4] ##[1:SOFT_RESET_REQUEST_LIM] !host_soft_reset_out;
  endsequence

  property p_pready_answer; psel_in && !penable_in |=> pready_out; endproperty
  property p_pready_pulse;  pready_out |=> !pready_out; endproperty
  property p_err_read; pslverr_out |-> pready_out && !pwrite_in; endproperty
  property p_early_refuse;
    // The ready port lags the internal flag by the same cycle as the answer
    rd_done && paddr_in == 12'h0A0 && !device_ready_out |-> pslverr_out;
  endproperty
  property p_early_answer;
    rd_done && (paddr_in == 12'h064 || paddr_in == 12'h074 || paddr_in == 12'h084
      || paddr_in == 12'h0F8) |-> !pslverr_out;
  endproperty
  property p_ready_cfg;
    rd_done && paddr_in == 12'h074 |-> prdata_out[27] == device_ready_out;
  endproperty
  property p_ready_pmt;
    rd_done && paddr_in == 12'h084 |-> prdata_out[0] == device_ready_out;
  endproperty
  property p_ready_low; host_soft_reset_out && $past(host_soft_reset_out) |-> !device_ready_out;
  endproperty
  property p_soft_reset_request_hold; s_soft_reset_request_wr |-> s_soft_reset_request_hold; endproperty
  property p_ready_after;
    $fell(host_soft_reset_out) |-> !device_ready_out [*4] ##[1:RDY_LIM] device_ready_out;
  endproperty
  property p_split;
    device_ready_out && !host_soft_reset_out |-> tx_sts_bytes_out == 15'h0200
      && (tx_sts_bytes_out + tx_data_bytes_out + rx_bytes_out) == 15'h4000;
  endproperty

  a_pready_answer: assert property (p_pready_answer) else $error("no pready after setup");
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
  a_err_read: assert property (p_err_read) else $error("pslverr outside a read answer");
  a_early_refuse: assert property (p_early_refuse) else $error("read allowed while not ready");
  a_early_answer: assert property (p_early_answer) else $error("early register refused");
  a_ready_cfg: assert property (p_ready_cfg) else $error("config ready bit differs");
  a_ready_pmt: assert property (p_ready_pmt) else $error("power ready bit differs");
  a_ready_low: assert property (p_ready_low) else $error("ready high during reset");
  a_soft_reset_request_hold: assert property (p_soft_reset_request_hold) else $error("soft reset hold wrong");
  a_ready_after: assert property (p_ready_after) else $error("ready timing wrong");
  a_split: assert property (p_split) else $error("fifo split wrong");
endmodule // hcf_config_regs_properties

bind hcf_config_regs hcf_config_regs_properties #(
  .SOFT_RESET_REQUEST_CYCLES(SOFT_RESET_REQUEST_CYCLES),
  .READY_CYCLES(READY_CYCLES)
) i_hcf_config_regs_properties (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .host_soft_reset_out(host_soft_reset_out), .device_ready_out(device_ready_out),
  .tx_sts_bytes_out(tx_sts_bytes_out), .tx_data_bytes_out(tx_data_bytes_out),
  .rx_bytes_out(rx_bytes_out)
);

`default_nettype wire

// [verif/hcf_config_regs_tb.sv]
// Purpose : Self-checking bench for the configuration register block
// Assumes : APB master in the bench, shortened reset and ready counts
// Notes   : Each scenario is one task
`default_nettype none

module hcf_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic        tx_err_event_in = 1'b0;
  logic        rx_err_event_in = 1'b0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        host_soft_reset_out;
  logic        device_ready_out;
  logic [14:0] tx_sts_bytes_out;
  logic [14:0] tx_data_bytes_out;
  logic [14:0] rx_bytes_out;
  logic [31:0] rd_q;
  logic        rd_e;
  int          bad_count = 0;
  int          compares = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  hcf_config_regs #(.SOFT_RESET_REQUEST_CYCLES(6), .READY_CYCLES(16)) i_hcf_config_regs (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .tx_err_event_in(tx_err_event_in), .rx_err_event_in(rx_err_event_in),
    .host_soft_reset_out(host_soft_reset_out), .device_ready_out(device_ready_out),
    .tx_sts_bytes_out(tx_sts_bytes_out), .tx_data_bytes_out(tx_data_bytes_out),
    .rx_bytes_out(rx_bytes_out)
  );

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Entered just after a rising edge; leaves one idle edge behind it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    // Waits however long the answer takes; only the watchdog ends a hang
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1);
    check("pready_wait", 32'h1, 32'(n));
    rd_q = prdata_out;
    rd_e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      rd(12'h084);
      k++;
    end while (rd_q[0] !== 1'b1 && k < 40);
    check("ready_poll", 32'h1, 32'(rd_q[0]));
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_after_reset;
    rd(12'h0A0);
    check("early_refuse", 32'h1, 32'(rd_e));
    rd(12'h074);
    check("alloc_reset", 32'h5, 32'(rd_q[19:16]));
    check("ready_low", 32'h0, 32'(rd_q[27]));
    rd(12'h064);
    check("byte_test", 32'h8765_4321, rd_q);
    rd(12'h0F8);
    check("reset_control_reg_err", 32'h0, 32'(rd_e));
    wait_ready;
    rd(12'h074);
    check("ready_cfg", 32'h1, 32'(rd_q[27]));
    rd(12'h0C0);
    check("unmapped_err", 32'h1, 32'(rd_e));
  endtask

  task automatic t_alloc;
    logic [3:0] v [4] = '{4'h2, 4'hE, 4'hF, 4'h5};
    int e;
    foreach (v[i]) begin
      e = (v[i] > 4'hE) ? 14 : int'(v[i]);
      wr(12'h074, 32'h0010_0000 | (32'(v[i]) << 16));
      rd(12'h074);
      check("alloc", 32'(e), 32'(rd_q[19:16]));
      check("cfg_rsv", 32'h0, 32'(rd_q[13:12]));
      check("tx_sts", 32'h0000_0200, 32'(tx_sts_bytes_out));
      check("tx_data", 32'(e * 1024 - 512), 32'(tx_data_bytes_out));
      check("rx", 32'(16384 - e * 1024), 32'(rx_bytes_out));
    end
  endtask

  task automatic t_soft_reset;
    wr(12'h074, 32'h0018_0000);
    wr(12'h0A0, 32'hA5A5_0001);
    wr(12'h084, 32'h0000_0040);
    tx_err_event_in <= 1'b1;
    rx_err_event_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    tx_err_event_in <= 1'b0;
    rx_err_event_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rd(12'h0A4);
    check("err_set", 32'h3, 32'(rd_q[1:0]));
    wr(12'h074, 32'h0018_0001);
    rd(12'h074);
    check("soft_reset_request_busy", 32'h1, 32'(rd_q[0]));
    wait_ready;
    rd(12'h074);
    check("soft_reset_request_clear", 32'h0, 32'(rd_q[0]));
    check("alloc_soft_reset_request", 32'h5, 32'(rd_q[19:16]));
    rd(12'h0A0);
    check("scratch_soft_reset_request", 32'h0, rd_q);
    rd(12'h084);
    check("kept_bit", 32'h1, 32'(rd_q[6]));
    rd(12'h0A4);
    check("err_soft_reset_request", 32'h0, 32'(rd_q[1:0]));
  endtask

  task automatic t_digital_reset;
    wr(12'h0F8, 32'h0000_0001);
    rd(12'h074);
    check("soft_reset_request_dig", 32'h1, 32'(rd_q[0]));
    wait_ready;
    rd(12'h084);
    check("kept_dig", 32'h0, 32'(rd_q[6]));
  endtask

  // --------------------------------------------------------------------------
  // Sequence and verdict
  // --------------------------------------------------------------------------
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_after_reset;
    t_alloc;
    t_soft_reset;
    t_digital_reset;
    complete_run;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    $display("MISMATCH watchdog expected finish seen timeout");
    complete_run;
  end
endmodule // hcf_config_regs_tb

`default_nettype wire
